// ==== trs_defines.svh ====
/*
 * register map, field positions, reset values and timing figures of the
 * timing reference selector.
 * assumes inclusion by bare name from package and module files.
 */
`ifndef TRS_DEFINES_SVH
`define TRS_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte addresses (low address bits)
`define TRS_ADDR_W          4
`define TRS_ADDR_CTRL       4'h0
`define TRS_ADDR_MODE       4'h4
`define TRS_ADDR_CMD        4'h8
`define TRS_ADDR_STATUS     4'hC

////////////////////////////////////////////////////////////////////////////////
// control register fields
`define TRS_CTRL_REVERT_BIT 0
`define TRS_CTRL_WTR_LSB    4
`define TRS_CTRL_WTR_MSB    7
`define TRS_WTR_RESET       4'h5
`define TRS_WTR_MAX         4'hC
`define TRS_REVERT_RESET    1'b0

// mode and command fields
`define TRS_MODE_MSB        1
`define TRS_CMD_MSB         2
`define TRS_CMD_ACT_LSB     4
`define TRS_CMD_ACT_MSB     6

// status register fields
`define TRS_ST_STATE_LSB    0
`define TRS_ST_STATE_MSB    1
`define TRS_ST_SEL_BIT      2
`define TRS_ST_OP_LSB       4
`define TRS_ST_OP_MSB       6
`define TRS_ST_DENIED_BIT   8
`define TRS_ST_MODEREJ_BIT  9
`define TRS_ST_MAIN_BIT     12
`define TRS_ST_STBY_BIT     13

////////////////////////////////////////////////////////////////////////////////
// timing figures
`define TRS_CLK_HZ          25000000
`define TRS_MINUTE_S        60

`endif

// ==== trs_pkg.sv ====
/*
 * types shared by the timing reference selector files.
 * assumes trs_defines.svh sits in the same folder.
 */
`include "trs_defines.svh"

package trs_pkg;

   // timing mode: internal oscillator or one of the automatic source sets
   typedef enum logic [1:0] {
      TRS_MODE_INTERNAL,
      TRS_MODE_OPT_PAIR,
      TRS_MODE_OPT_SINGLE,
      TRS_MODE_TRIB_PAIR
   } trs_mode_t;

   // operator switch commands, in issue code order
   typedef enum logic [2:0] {
      TRS_CMD_NONE,
      TRS_CMD_CLEAR,
      TRS_CMD_INHIBIT,
      TRS_CMD_FORCE_STBY,
      TRS_CMD_FORCE_MAIN,
      TRS_CMD_MAN_STBY,
      TRS_CMD_MAN_MAIN,
      TRS_CMD_RSVD
   } trs_cmd_t;

   // timing state
   typedef enum logic [1:0] {
      TRS_TS_FREERUN,
      TRS_TS_NORMAL,
      TRS_TS_HOLDOVER
   } trs_state_t;

   // operation status indication
   typedef enum logic [2:0] {
      TRS_OP_NORMAL,
      TRS_OP_UNAVAIL,
      TRS_OP_WAIT_RESTORE,
      TRS_OP_MANUAL,
      TRS_OP_FORCED,
      TRS_OP_INHIBIT
   } trs_op_t;

endpackage

// ==== trs_wtr_timer.sv ====
/*
 * wait-to-restore timer: minute tick from the system clock and a
 * minute counter compared against the programmed interval.
 * assumes run drops whenever the waiting condition is lost.
 */
`timescale 1ns/1ps
`include "trs_defines.svh"

module trs_wtr_timer
   import trs_pkg::*;
#(
   parameter int unsigned MINUTE_CYCLES = `TRS_MINUTE_S * `TRS_CLK_HZ
) (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       run,
   input  wire logic [3:0] minutes,
   output logic            done
);

   if (MINUTE_CYCLES < 1) begin : g_chk
      $error("minute length must be at least one cycle");
   end

   logic [31:0] cyc;
   logic [31:0] next_cyc;
   logic [3:0]  mins;
   logic [3:0]  next_mins;
   logic        next_done;

   ////////////////////////////////////////////////////////////////////////////
   // count cycles into minutes, restart from zero when run drops
   always_comb begin
      next_cyc  = cyc;
      next_mins = mins;
      if (!run) begin
         next_cyc  = 32'h0000_0000;
         next_mins = 4'h0;
      end else if (mins < minutes) begin
         if (cyc == 32'(MINUTE_CYCLES - 1)) begin
            next_cyc  = 32'h0000_0000;
            next_mins = mins + 4'h1;
         end else begin
            next_cyc = cyc + 32'h0000_0001;
         end
      end
      next_done = run && (next_mins >= minutes);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc  <= 32'h0000_0000;
         mins <= 4'h0;
         done <= 1'b0;
      end else begin
         cyc  <= next_cyc;
         mins <= next_mins;
         done <= next_done;
      end
   end

endmodule

// ==== trs_selector.sv ====
/*
 * timing reference selector: chooses the main or standby recovered
 * reference, applies operator switch commands, times wait-to-restore and
 * reports timing state and operation status; registers over AHB-Lite.
 * assumes a single slave on the bus, synchronous reference status inputs
 * and a hitless phase-locked loop downstream of sel_standby.
 */
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "trs_defines.svh"

// Overview of operation
// - mode change from optical pair straight to tributary pair is refused.
// - revertive: main recovery returns to main only after wait-to-restore interval elapses.
// - non-revertive: main recovery alone never causes return to main.
// - non-revertive return to main: completed command, or standby fails.
// - reset selects non-revertive switching.
// - wait-to-restore setting has no effect in non-revertive operation.
// - interval is 0 to 12 whole minutes, default 5.
// - status shows wait-to-restore while revertive return is pending and inhibit is not active.
// - clear always completes and cancels every active command.
// - inhibit always completes; no switch to standby while active.
// - force to standby denied if standby invalid or inhibit active.
// - force to main denied only while inhibit active.
// - manual denied if target invalid or inhibit or force active.
// - manual switching is hitless on the system clock.
// - accepted command holds until clear, a command of equal or higher priority, or overriding failure.
// - status reports manual, forced or inhibit while a command is active.
// - pending command reads no-command after reset.
// - main failure moves to standby unless inhibit or force to main.
// - holdover ends as soon as the selected reference becomes available.
// - reset starts in free-run until an automatic mode is set and a valid reference appears.
module trs_selector
   import trs_pkg::*;
#(
   parameter int unsigned MINUTE_CYCLES = `TRS_MINUTE_S * `TRS_CLK_HZ
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        main_ref_ok,
   input  wire logic        standby_ref_ok,
   output logic             sel_standby,
   output logic [1:0]       timing_state,
   output logic [2:0]       op_status
);

   if (MINUTE_CYCLES < 1) begin : g_chk
      $error("minute length must be at least one cycle");
   end

   // is a command kind one of the two forced switches
   function automatic logic is_forced(input trs_cmd_t c);
      return (c == TRS_CMD_FORCE_STBY) || (c == TRS_CMD_FORCE_MAIN);
   endfunction

   // does a command kind keep the standby reference selected
   function automatic logic holds_standby(input trs_cmd_t c);
      return (c == TRS_CMD_FORCE_STBY) || (c == TRS_CMD_MAN_STBY);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus slave state
   logic                   wr_pend;
   logic [`TRS_ADDR_W-1:0] wr_addr;
   logic                   next_wr_pend;
   logic [`TRS_ADDR_W-1:0] next_wr_addr;
   logic [31:0]            next_hrdata;
   logic                   addr_ok;

   // software visible controls
   logic                   revertive;
   logic [3:0]             wtr_minutes;
   trs_mode_t              mode;
   trs_cmd_t               pend_cmd;
   logic                   denied;
   logic                   mode_rej;
   logic                   next_revertive;
   logic [3:0]             next_wtr_minutes;
   trs_mode_t              next_mode;
   trs_cmd_t               next_pend_cmd;
   logic                   next_denied;
   logic                   next_mode_rej;
   logic                   issue;
   trs_cmd_t               issue_cmd;

   // selection state
   trs_cmd_t               active;
   trs_state_t             tstate;
   logic                   next_sel;
   trs_cmd_t               next_active;
   trs_state_t             next_tstate;
   trs_op_t                next_op;
   logic                   auto_mode;
   logic                   main_avail;
   logic                   stby_avail;
   logic                   wtr_run;
   logic                   wtr_done;
   logic                   deny;

   ////////////////////////////////////////////////////////////////////////////
   // address phase capture and read data
   assign addr_ok = hsel && htrans[1] && hready;

   always_comb begin
      next_wr_pend = addr_ok && hwrite;
      next_wr_addr = wr_addr;
      next_hrdata  = hrdata;
      if (addr_ok) begin
         next_wr_addr = haddr[`TRS_ADDR_W-1:0];
      end
      if (addr_ok && !hwrite) begin
         next_hrdata = 32'h0000_0000;                  // unmapped reads zero
         unique case (haddr[`TRS_ADDR_W-1:0])
            `TRS_ADDR_CTRL: begin
               next_hrdata[`TRS_CTRL_REVERT_BIT]               = revertive;
               next_hrdata[`TRS_CTRL_WTR_MSB:`TRS_CTRL_WTR_LSB] = wtr_minutes;
            end
            `TRS_ADDR_MODE: next_hrdata[`TRS_MODE_MSB:0] = mode;
            `TRS_ADDR_CMD: begin
               next_hrdata[`TRS_CMD_MSB:0]                       = pend_cmd;
               next_hrdata[`TRS_CMD_ACT_MSB:`TRS_CMD_ACT_LSB]   = active;
            end
            `TRS_ADDR_STATUS: begin
               next_hrdata[`TRS_ST_STATE_MSB:`TRS_ST_STATE_LSB] = tstate;
               next_hrdata[`TRS_ST_SEL_BIT]                     = sel_standby;
               next_hrdata[`TRS_ST_OP_MSB:`TRS_ST_OP_LSB]       = op_status;
               next_hrdata[`TRS_ST_DENIED_BIT]                  = denied;
               next_hrdata[`TRS_ST_MODEREJ_BIT]                 = mode_rej;
               next_hrdata[`TRS_ST_MAIN_BIT]                    = main_avail;
               next_hrdata[`TRS_ST_STBY_BIT]                    = stby_avail;
            end
            default: next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         wr_addr   <= '0;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;                            // zero wait states
         hresp     <= 1'b0;                            // always OKAY
      end else begin
         wr_pend   <= next_wr_pend;
         wr_addr   <= next_wr_addr;
         hrdata    <= next_hrdata;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software controls, written in the data phase
   assign issue     = wr_pend && (wr_addr == `TRS_ADDR_CMD);
   assign issue_cmd = trs_cmd_t'(hwdata[`TRS_CMD_MSB:0]);

   always_comb begin
      next_revertive   = revertive;
      next_wtr_minutes = wtr_minutes;
      next_mode        = mode;
      next_pend_cmd    = pend_cmd;
      next_mode_rej    = mode_rej;
      next_denied      = denied;
      if (wr_pend && (wr_addr == `TRS_ADDR_CTRL)) begin
         next_revertive = hwdata[`TRS_CTRL_REVERT_BIT];
         if (hwdata[`TRS_CTRL_WTR_MSB:`TRS_CTRL_WTR_LSB] <= `TRS_WTR_MAX) begin
            next_wtr_minutes = hwdata[`TRS_CTRL_WTR_MSB:`TRS_CTRL_WTR_LSB];
         end
      end
      if (wr_pend && (wr_addr == `TRS_ADDR_MODE)) begin
         if ((mode == TRS_MODE_OPT_PAIR || mode == TRS_MODE_OPT_SINGLE) &&
             (trs_mode_t'(hwdata[`TRS_MODE_MSB:0]) == TRS_MODE_TRIB_PAIR)) begin
            next_mode_rej = 1'b1;
         end else begin
            next_mode = trs_mode_t'(hwdata[`TRS_MODE_MSB:0]);
         end
      end
      if (issue) begin
         next_pend_cmd = issue_cmd;
      end
      // write one clears; a new event in the same cycle wins
      if (wr_pend && (wr_addr == `TRS_ADDR_STATUS)) begin
         if (hwdata[`TRS_ST_DENIED_BIT]) next_denied = 1'b0;
         if (hwdata[`TRS_ST_MODEREJ_BIT] &&
             !(next_mode_rej && !mode_rej)) next_mode_rej = 1'b0;
      end
      if (deny) begin
         next_denied = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         revertive   <= `TRS_REVERT_RESET;
         wtr_minutes <= `TRS_WTR_RESET;
         mode        <= TRS_MODE_INTERNAL;
         pend_cmd    <= TRS_CMD_NONE;
         denied      <= 1'b0;
         mode_rej    <= 1'b0;
      end else begin
         revertive   <= next_revertive;
         wtr_minutes <= next_wtr_minutes;
         mode        <= next_mode;
         pend_cmd    <= next_pend_cmd;
         denied      <= next_denied;
         mode_rej    <= next_mode_rej;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reference availability in the current mode
   assign auto_mode  = (mode != TRS_MODE_INTERNAL);
   assign main_avail = auto_mode && main_ref_ok;
   assign stby_avail = auto_mode && (mode != TRS_MODE_OPT_SINGLE) && standby_ref_ok;

   // waiting to return to main: revertive only, no command holding standby
   assign wtr_run = revertive && sel_standby && main_avail && stby_avail &&
                    !holds_standby(active);

   trs_wtr_timer #(
      .MINUTE_CYCLES (MINUTE_CYCLES)
   ) u_wtr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (wtr_run),
      .minutes (wtr_minutes),
      .done    (wtr_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // command acceptance, failure override and reference selection
   always_comb begin
      next_active = active;
      next_sel    = sel_standby;
      deny        = 1'b0;
      // failures override the command they defeat
      if ((active == TRS_CMD_FORCE_STBY || active == TRS_CMD_MAN_STBY) && !stby_avail) begin
         next_active = TRS_CMD_NONE;
      end
      if (active == TRS_CMD_MAN_MAIN && !main_avail) begin
         next_active = TRS_CMD_NONE;
      end
      if (issue) begin
         unique case (issue_cmd)
            TRS_CMD_CLEAR:   next_active = TRS_CMD_NONE;
            TRS_CMD_INHIBIT: next_active = TRS_CMD_INHIBIT;
            TRS_CMD_FORCE_STBY: begin
               if (!stby_avail || active == TRS_CMD_INHIBIT) begin
                  deny = 1'b1;
               end else begin
                  next_active = TRS_CMD_FORCE_STBY;
                  next_sel    = 1'b1;
               end
            end
            TRS_CMD_FORCE_MAIN: begin
               if (active == TRS_CMD_INHIBIT) begin
                  deny = 1'b1;
               end else begin
                  next_active = TRS_CMD_FORCE_MAIN;
                  next_sel    = 1'b0;
               end
            end
            TRS_CMD_MAN_STBY, TRS_CMD_MAN_MAIN: begin
               if ((issue_cmd == TRS_CMD_MAN_STBY ? !stby_avail : !main_avail) ||
                   active == TRS_CMD_INHIBIT || is_forced(active)) begin
                  deny = 1'b1;
               end else begin
                  next_active = issue_cmd;
                  next_sel    = (issue_cmd == TRS_CMD_MAN_STBY);
               end
            end
            default: next_active = next_active;             // no command
         endcase
      end
      // automatic selection unless a force, manual or reserved code was issued and not denied
      if (!auto_mode) begin
         next_sel = 1'b0;
      end else if (!(issue && !deny && issue_cmd != TRS_CMD_CLEAR &&
                     issue_cmd != TRS_CMD_INHIBIT && issue_cmd != TRS_CMD_NONE)) begin
         if (!sel_standby) begin
            if (!main_avail && stby_avail && next_active != TRS_CMD_INHIBIT &&
                next_active != TRS_CMD_FORCE_MAIN) begin
               next_sel = 1'b1;
            end
         end else if (!holds_standby(next_active)) begin
            if (!stby_avail && main_avail) begin
               next_sel = 1'b0;
            end else if (wtr_run && wtr_done) begin
               next_sel = 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timing state and operation status
   always_comb begin
      next_tstate = tstate;
      if (!auto_mode) begin
         next_tstate = TRS_TS_FREERUN;
      end else begin
         unique case (tstate)
            TRS_TS_FREERUN:
               if (next_sel ? stby_avail : main_avail) next_tstate = TRS_TS_NORMAL;
            TRS_TS_NORMAL:
               if (!(next_sel ? stby_avail : main_avail)) next_tstate = TRS_TS_HOLDOVER;
            TRS_TS_HOLDOVER:
               if (next_sel ? stby_avail : main_avail) next_tstate = TRS_TS_NORMAL;
            default: next_tstate = TRS_TS_FREERUN;
         endcase
      end
      // commands first, then the return wait, then missing references
      if (next_active == TRS_CMD_INHIBIT) begin
         next_op = TRS_OP_INHIBIT;
      end else if (is_forced(next_active)) begin
         next_op = TRS_OP_FORCED;
      end else if (next_active == TRS_CMD_MAN_STBY || next_active == TRS_CMD_MAN_MAIN) begin
         next_op = TRS_OP_MANUAL;
      end else if (wtr_run && next_sel) begin
         next_op = TRS_OP_WAIT_RESTORE;
      end else if (auto_mode && !(main_avail && stby_avail)) begin
         next_op = TRS_OP_UNAVAIL;
      end else begin
         next_op = TRS_OP_NORMAL;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         active       <= TRS_CMD_NONE;
         tstate       <= TRS_TS_FREERUN;
         sel_standby  <= 1'b0;
         timing_state <= TRS_TS_FREERUN;
         op_status    <= TRS_OP_NORMAL;
      end else begin
         active       <= next_active;
         tstate       <= next_tstate;
         sel_standby  <= next_sel;
         timing_state <= next_tstate;
         op_status    <= next_op;
      end
   end

endmodule

// ==== trs_ref_src.sv ====
/* line-side reference source: availability levels after a lag.
   assumes the bench sets the wanted levels and the lag. */
`timescale 1ns/1ps
module trs_ref_src (
   input  wire logic       hclk,
   input  wire logic       want_main,
   input  wire logic       want_stby,
   input  wire logic [3:0] lag,
   output logic            main_ref_ok,
   output logic            standby_ref_ok
);
   logic [15:0] hist_m = '1;
   logic [15:0] hist_s = '1;
   //////////////////////////////////////////////////
   // delay line, so changes arrive promptly or slowly
   always_ff @(posedge hclk) begin
      hist_m <= {hist_m[14:0], want_main};
      hist_s <= {hist_s[14:0], want_stby};
   end
   assign main_ref_ok    = hist_m[lag];
   assign standby_ref_ok = hist_s[lag];
endmodule

// ==== trs_selector_checker.sv ====
/* port checker for the selector: bus answer and reference switching.
   assumes a bind to trs_selector and the bench's short minute. */
`timescale 1ns/1ps
module trs_selector_checker
   import trs_pkg::*;
(
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       main_ref_ok,
   input wire logic       standby_ref_ok,
   input wire logic       sel_standby,
   input wire logic [1:0] timing_state,
   input wire logic [2:0] op_status
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   //////////////////////////////////////////////////
   // loss of the selected reference, main loss only with no command holding it
   sequence main_lost;
      $fell(main_ref_ok) && standby_ref_ok && !sel_standby
      && timing_state != TRS_TS_FREERUN && op_status < 3;
   endsequence
   sequence stby_lost;
      $fell(standby_ref_ok) && main_ref_ok && sel_standby;
   endsequence
   a_ready_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready okay");
   a_fail_over: assert property (main_lost |-> ##[1:3] sel_standby)
      else $error("no move to standby");
   a_fail_back: assert property (stby_lost |-> ##[1:3] !sel_standby)
      else $error("no return to main");
   a_inhibit_hold: assert property ($rose(sel_standby) |-> op_status != TRS_OP_INHIBIT)
      else $error("standby taken under inhibit");
   a_stby_valid: assert property ($rose(sel_standby) |-> $past(standby_ref_ok))
      else $error("standby taken while invalid");
   a_normal_cause: assert property ($rose(timing_state == TRS_TS_NORMAL)
      |-> $past(main_ref_ok || standby_ref_ok))
      else $error("normal without a reference");
   a_holdover_end: assert property (timing_state == TRS_TS_HOLDOVER
      && (sel_standby ? standby_ref_ok : main_ref_ok)
      |-> ##[1:3] timing_state == TRS_TS_NORMAL)
      else $error("holdover kept");
   a_wtr_stby: assert property (op_status == TRS_OP_WAIT_RESTORE
      |-> sel_standby && $past(main_ref_ok && standby_ref_ok))
      else $error("wait shown on main");
   a_wtr_cause: assert property ($fell(sel_standby)
      && $past(op_status) == TRS_OP_WAIT_RESTORE |-> $past(main_ref_ok))
      else $error("return without main");
endmodule

bind trs_selector trs_selector_checker chk_u (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .main_ref_ok(main_ref_ok),
   .standby_ref_ok(standby_ref_ok), .sel_standby(sel_standby),
   .timing_state(timing_state), .op_status(op_status));

// ==== test_timing_reference_selector.sv ====
/* bench for the timing reference selector: bus tasks, command model.
   assumes the checker binds itself and the source model drives refs. */
`timescale 1ns/1ps
module test_timing_reference_selector;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = '0;
   logic        hready, hreadyout, hresp, main_ref_ok, standby_ref_ok, sel_standby;
   logic [31:0] hrdata, rd;
   logic [1:0]  timing_state;
   logic [2:0]  op_status;
   logic        want_m = 1'b1;
   logic        want_s = 1'b1;
   logic [3:0]  lag = 4'h0;
   int          failures = 0;
   int          tests_run = 0;
   int          act = 0, msel = 0, mden = 0, s_ok = 1;
   int          cl[] = '{0, 7, 2, 3, 6, 1, 3, 6, 4, 1, 5, 6, 1};

   always #20 hclk = ~hclk;
   assign hready = hreadyout;
   trs_selector #(.MINUTE_CYCLES(10)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .main_ref_ok(main_ref_ok), .standby_ref_ok(standby_ref_ok),
      .sel_standby(sel_standby), .timing_state(timing_state), .op_status(op_status));
   trs_ref_src src_u (.hclk(hclk), .want_main(want_m), .want_stby(want_s), .lag(lag),
      .main_ref_ok(main_ref_ok), .standby_ref_ok(standby_ref_ok));

   //////////////////////////////////////////////////
   // comparison, verdict and bounded waits
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // k picks sel, state, main ok or standby ok
   task automatic wt(input int k, input logic [1:0] v);
      int n;
      logic [1:0] s;
      for (n = 0; n < 60; n++) begin
         s = k == 0 ? 2'(sel_standby) : k == 1 ? timing_state
           : k == 2 ? 2'(main_ref_ok) : 2'(standby_ref_ok);
         if (s === v) break;
         @(posedge hclk);
      end
      check("wait", v, s);
      if (n >= 60) stop_test();
   endtask
   // one single AHB-Lite transfer, address phase then data phase
   task automatic bus(input bit wr, input logic [3:0] off, input logic [31:0] wd,
                      output logic [31:0] q);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {28'($urandom), off};
      htrans <= 2'h2;
      hwrite <= wr;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
      q = hrdata;
      if (n >= 50) begin failures++; stop_test(); end
   endtask
   // expected outcome of a command from priorities and denials
   task automatic cmd(input int c);
      int dn, op;
      dn = c > 2 && c < 7 && (act == 2 || (c > 4 && (act == 3 || act == 4))
         || ((c == 3 || c == 5) && !s_ok) || (c == 6 && !want_m));
      mden = dn;
      if (!dn && c != 0 && c != 7) begin  // code 7 is ignored
         act = c == 1 ? 0 : c;
         if (c == 3 || c == 5) msel = 1;
         if (c == 4 || c == 6) msel = 0;
      end
      op = act == 0 ? (s_ok ? 0 : 1) : act == 2 ? 5 : act < 5 ? 4 : 3;
      bus(1, 4'h8, c, rd);
      bus(0, 4'hC, 0, rd);
      check("sel", msel, rd[2]);
      check("op", op, rd[6:4]);
      check("denied", mden, rd[8]);
      bus(1, 4'hC, 32'h100, rd);
   endtask

   initial begin
      int n;
      void'($urandom(32'hC088));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      bus(0, 4'h0, 0, rd);
      check("ctrl", 32'h50, rd);
      bus(0, 4'h8, 0, rd);
      check("cmd", 0, rd);
      bus(0, 4'hC, 0, rd);
      check("state", 0, rd[1:0]);
      $display("test reset done");
      // modes: direct optical to tributary refused
      bus(1, 4'h4, 1, rd);
      bus(1, 4'h4, 3, rd);
      bus(0, 4'h4, 0, rd);
      check("mode", 1, rd[1:0]);
      bus(0, 4'hC, 0, rd);
      check("rejected", 1, rd[9]);
      bus(1, 4'hC, 32'h200, rd);
      bus(1, 4'h4, 2, rd);
      bus(1, 4'h4, 3, rd);               // optical single to tributary refused
      bus(0, 4'h4, 0, rd);
      check("mode", 2, rd[1:0]);
      bus(1, 4'h4, 0, rd);
      bus(1, 4'h4, 3, rd);
      bus(0, 4'h4, 0, rd);
      check("mode", 3, rd[1:0]);
      bus(1, 4'h4, 0, rd);
      bus(1, 4'h4, 1, rd);               // commands only in auto mode
      wt(1, 1);
      $display("test mode done");
      foreach (cl[i]) cmd(cl[i]);
      want_s <= 1'b0;
      s_ok = 0;
      wt(3, 0);
      cmd(5);
      want_s <= 1'b1;
      s_ok = 1;
      wt(3, 1);
      $display("test commands done");
      // non-revertive failover, stay, return and holdover
      lag <= 4'($urandom % 8);
      want_m <= 1'b0;
      wt(0, 1);
      want_m <= 1'b1;
      wt(2, 1);
      repeat (100) @(posedge hclk);
      check("stay", 1, sel_standby);
      want_s <= 1'b0;
      wt(0, 0);
      want_m <= 1'b0;
      wt(1, 2);
      want_m <= 1'b1;
      wt(1, 1);
      want_s <= 1'b1;
      wt(3, 1);
      $display("test non-revertive done");
      // revertive return after a restarted wait
      bus(1, 4'h0, 32'hC0, rd);
      bus(0, 4'h0, 0, rd);
      check("ctrl", 32'hC0, rd);
      bus(1, 4'h0, 32'hD1, rd);
      bus(0, 4'h0, 0, rd);
      check("ctrl", 32'hC1, rd);
      bus(1, 4'h0, 32'h21, rd);
      want_m <= 1'b0;
      wt(0, 1);
      want_m <= 1'b1;
      wt(2, 1);
      repeat (10) @(posedge hclk);
      check("op", 2, op_status);
      want_m <= 1'b0;
      wt(2, 0);
      want_m <= 1'b1;
      wt(2, 1);
      for (n = 0; n < 40 && sel_standby === 1'b1; n++) @(posedge hclk);
      check("wtr", 1, n >= 20 && n <= 24);
      $display("test revertive done");
      stop_test();
   end
endmodule
